// File: pcd_phase_decode.sv
/*
  pcd_phase_decode: bus front end that finds address and data phases,
  captures address and command, claims matching transactions as a
  simple target and drives the sustained lines with proper handover.
  assumes all pin inputs are synchronous to CLOCK_I and that the
  surrounding pad logic resolves each line from its output enable.
*/
`timescale 1ns/1ps
module pcd_phase_decode
  import pcd_pkg::*;
#(
  parameter logic [31:0] MEM_BASE = 32'h1000_0000,
  parameter logic [31:0] MEM_MASK = 32'hffff_f000,
  parameter logic [31:0] IO_BASE = 32'h0000_1000,
  parameter logic [31:0] IO_MASK = 32'hffff_ff00
)
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // bus lines as seen on the wire
  input wire logic [31:0] AD_I,
  input wire logic [3:0] CBE_N_I,
  input wire logic FRAME_N_I,
  input wire logic IRDY_N_I,
  input wire logic TRDY_N_I,
  input wire logic IDSEL_I,
  // bus lines driven by this target
  output logic [31:0] AD_O,
  output logic AD_OE_O,
  output logic DEVSEL_N_O,
  output logic DEVSEL_OE_O,
  output logic TRDY_N_O,
  output logic TRDY_OE_O,
  // open-drain attention line
  output logic ATTN_N_O,
  output logic ATTN_OE_O,
  // user side: requests and read data
  input wire logic ATTN_REQ_I,
  input wire logic TARGET_READY_I,
  input wire logic [31:0] RD_DATA_I,
  // user side: decoded phase information
  output logic ADDR_PHASE_O,
  output logic [31:0] ADDR_O,
  output logic [3:0] CMD_CODE_O,
  output pcd_kind_t CMD_KIND_O,
  output logic CMD_RESERVED_O,
  output logic CMD_READ_O,
  output logic CLAIMED_O,
  output logic ACTIVE_O,
  output logic XFER_O,
  output logic [31:0] XFER_DATA_O,
  output logic [3:0] XFER_BE_O,
  output logic XFER_LAST_O,
  output logic BUS_XFER_O
);
  pcd_state_t state;
  pcd_state_t next_state;
  logic bus_idle;
  logic read_q;
  logic turn_done;
  logic [31:0] next_addr;

  pcd_kind_t dec_kind;
  logic dec_reserved;
  logic dec_read;
  logic dec_mem;
  logic dec_io;
  logic dec_cfg;

  // command lines carry the code only in the address phase
  pcd_cmd_decode u_cmd_decode
  (
    .cmd_i(CBE_N_I),
    .kind_o(dec_kind),
    .reserved_o(dec_reserved),
    .is_read_o(dec_read),
    .is_mem_o(dec_mem),
    .is_io_o(dec_io),
    .is_cfg_o(dec_cfg)
  );

  // active-low frame, irdy and trdy lines are inverted once, here
  wire frame_act = ~FRAME_N_I;
  wire irdy_act = ~IRDY_N_I;
  wire trdy_act = ~TRDY_N_I;

  // address phase: frame asserted on an idle bus
  wire addr_phase = frame_act & bus_idle;
  // a data word moves only when both ready lines are low
  wire bus_xfer = irdy_act & trdy_act;
  wire own_xfer = bus_xfer & (state == PCD_DATA);
  // last data phase: frame already released by the initiator
  wire last_phase = FRAME_N_I;
  // initiator gave up without a transfer
  wire init_gone = FRAME_N_I & IRDY_N_I;

  wire mem_hit = dec_mem & ((AD_I & MEM_MASK) == MEM_BASE);
  wire io_hit = dec_io & ((AD_I & IO_MASK) == IO_BASE);
  wire cfg_hit = dec_cfg & IDSEL_I & (AD_I[1:0] == CFG_TYPE0);
  // reserved codes never claim, whatever the address
  wire claim = addr_phase & ~dec_reserved & (mem_hit | io_hit | cfg_hit);

  // trdy for the next clock: held while waiting for irdy, dropped after a transfer
  // so the user sees the stepped address before new read data is taken
  wire trdy_low_now = ~TRDY_N_O & TRDY_OE_O;
  wire next_trdy = (state == PCD_DATA) & ~init_gone
                   & (own_xfer ? 1'b0 : (trdy_low_now | (TARGET_READY_I & turn_done)));
  wire load_rd = (state == PCD_DATA) & read_q & TARGET_READY_I & turn_done & ~trdy_low_now & ~own_xfer;

  assign next_addr = ADDR_O + ADDR_STEP;
  // never driven high, only pulled low or released
  assign ATTN_N_O = OD_LOW;

  always_comb
  begin
    next_state = state;
    case (state)
      PCD_IDLE:
      begin
        if (claim)
          next_state = PCD_DATA;
        else if (addr_phase)
          next_state = PCD_OTHER;
      end
      PCD_DATA:
      begin
        if ((own_xfer & last_phase) | init_gone)
          next_state = PCD_HOLD;
      end
      // a new address phase may follow the idle clock straight away
      PCD_HOLD:
      begin
        if (claim)
          next_state = PCD_DATA;
        else if (addr_phase)
          next_state = PCD_OTHER;
        else
          next_state = PCD_IDLE;
      end
      PCD_OTHER:
      begin
        if (init_gone)
          next_state = PCD_IDLE;
      end
      default:
        next_state = PCD_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state <= PCD_IDLE;
      bus_idle <= 1'b1;
    end
    else
    begin
      state <= next_state;
      bus_idle <= init_gone;
    end
  end

  // capture of address and command, stepped on each burst word
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ADDR_O <= ADDR_RST;
      CMD_CODE_O <= CMD_RST;
      CMD_KIND_O <= PCD_K_RESERVED;
      CMD_RESERVED_O <= 1'b0;
      CMD_READ_O <= 1'b0;
      read_q <= 1'b0;
    end
    else if (addr_phase)
    begin
      ADDR_O <= AD_I;
      CMD_CODE_O <= CBE_N_I;
      CMD_KIND_O <= dec_kind;
      CMD_RESERVED_O <= dec_reserved;
      CMD_READ_O <= dec_read;
      read_q <= dec_read;
    end
    else if (own_xfer)
    begin
      ADDR_O <= next_addr;
    end
  end

  // phase pulses and claim status
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ADDR_PHASE_O <= 1'b0;
      CLAIMED_O <= 1'b0;
      ACTIVE_O <= 1'b0;
      BUS_XFER_O <= 1'b0;
    end
    else
    begin
      ADDR_PHASE_O <= addr_phase;
      CLAIMED_O <= addr_phase ? claim : (CLAIMED_O & (next_state != PCD_IDLE));
      ACTIVE_O <= (next_state == PCD_DATA);
      BUS_XFER_O <= bus_xfer & ~bus_idle;
    end
  end

  // data phase capture: write or read data and lane enables
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      XFER_O <= 1'b0;
      XFER_LAST_O <= 1'b0;
      XFER_DATA_O <= DATA_RST;
      XFER_BE_O <= BE_RST;
    end
    else
    begin
      XFER_O <= own_xfer;
      XFER_LAST_O <= own_xfer & last_phase;
      if (own_xfer)
      begin
        XFER_DATA_O <= read_q ? AD_O : AD_I;
        // enable line n gates lane n, low means lane used
        XFER_BE_O <= ~CBE_N_I;
      end
    end
  end

  // address/data turnaround: the initiator drove the address in the
  // address phase, so the target waits two clocks before taking the lines
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      turn_done <= 1'b0;
    else
      turn_done <= (state == PCD_DATA) & (next_state == PCD_DATA);
  end

  // read data onto the shared lines
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      AD_O <= DATA_RST;
      AD_OE_O <= 1'b0;
    end
    else
    begin
      if (load_rd)
        AD_O <= RD_DATA_I;
      // only after the turnaround clock and only for reads
      AD_OE_O <= read_q & turn_done & (next_state == PCD_DATA);
    end
  end

  // sustained lines: select low while active, ready low only when ready, both high one clock in hold, then released
  // enable rises only from idle after a claim, which is at least one clock
  // past the previous owner's release since the bus was seen idle
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      DEVSEL_N_O <= 1'b1;
      DEVSEL_OE_O <= 1'b0;
      TRDY_N_O <= 1'b1;
      TRDY_OE_O <= 1'b0;
    end
    else
    begin
      DEVSEL_N_O <= ~(next_state == PCD_DATA);
      DEVSEL_OE_O <= (next_state == PCD_DATA) | (next_state == PCD_HOLD);
      TRDY_N_O <= ~next_trdy;
      TRDY_OE_O <= (next_state == PCD_DATA) | (next_state == PCD_HOLD);
    end
  end

  // attention: enable pulls the wire low, release lets the pullup win
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      ATTN_OE_O <= 1'b0;
    else
      ATTN_OE_O <= ATTN_REQ_I;
  end
endmodule

// File: pcd_cmd_decode.sv
/*
  pcd_pkg: shared constants, command kinds and state type for the
  bus phase and command decode front end.
  pcd_cmd_decode: purely combinational classifier of a 4-bit bus
  command code sampled in the address phase.
  assumes the code is taken from the command/byte-enable lines while
  the frame signal is asserted; it holds no state of its own.
*/
package pcd_pkg;
  localparam int AD_W = 32;
  localparam int BE_W = 4;
  localparam int CMD_W = 4;
  // command codes, line 3 down to line 0
  localparam logic [3:0] CMD_INT_ACK = 4'h0;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_RSVD_4 = 4'h4;
  localparam logic [3:0] CMD_RSVD_5 = 4'h5;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_RSVD_8 = 4'h8;
  localparam logic [3:0] CMD_RSVD_9 = 4'h9;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
  localparam logic [3:0] CMD_DUAL_ADDR = 4'hd;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;
  // burst address step and type-0 config marker in the low address bits
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  // reset values
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [3:0] CMD_RST = 4'h0;
  localparam logic [3:0] BE_RST = 4'h0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  // open-drain line is only ever pulled low
  localparam logic OD_LOW = 1'b0;

  typedef enum logic [3:0] {
    PCD_K_INT_ACK,
    PCD_K_SPECIAL,
    PCD_K_IO_RD,
    PCD_K_IO_WR,
    PCD_K_MEM_RD,
    PCD_K_MEM_WR,
    PCD_K_CFG_RD,
    PCD_K_CFG_WR,
    PCD_K_MEM_RD_MULT,
    PCD_K_DUAL_ADDR,
    PCD_K_MEM_RD_LINE,
    PCD_K_MEM_WR_INV,
    PCD_K_RESERVED
  } pcd_kind_t;

  typedef enum logic [2:0] {
    PCD_IDLE,
    PCD_DATA,
    PCD_HOLD,
    PCD_OTHER
  } pcd_state_t;
endpackage

`timescale 1ns/1ps
module pcd_cmd_decode
  import pcd_pkg::*;
(
  // command code from the address phase
  input wire logic [3:0] cmd_i,
  // classification
  output pcd_kind_t kind_o,
  output logic reserved_o,
  output logic is_read_o,
  output logic is_mem_o,
  output logic is_io_o,
  output logic is_cfg_o
);
  always_comb
  begin
    kind_o = PCD_K_RESERVED;
    case (cmd_i)
      CMD_INT_ACK: kind_o = PCD_K_INT_ACK;
      CMD_SPECIAL: kind_o = PCD_K_SPECIAL;
      CMD_IO_RD: kind_o = PCD_K_IO_RD;
      CMD_IO_WR: kind_o = PCD_K_IO_WR;
      CMD_RSVD_4: kind_o = PCD_K_RESERVED;
      CMD_MEM_RD: kind_o = PCD_K_MEM_RD;
      CMD_MEM_WR: kind_o = PCD_K_MEM_WR;
      CMD_CFG_RD: kind_o = PCD_K_CFG_RD;
      CMD_CFG_WR: kind_o = PCD_K_CFG_WR;
      CMD_MEM_RD_MULT: kind_o = PCD_K_MEM_RD_MULT;
      CMD_DUAL_ADDR: kind_o = PCD_K_DUAL_ADDR;
      CMD_MEM_RD_LINE: kind_o = PCD_K_MEM_RD_LINE;
      CMD_MEM_WR_INV: kind_o = PCD_K_MEM_WR_INV;
      CMD_RSVD_5, CMD_RSVD_8, CMD_RSVD_9: kind_o = PCD_K_RESERVED;
      default: kind_o = PCD_K_RESERVED;
    endcase
  end

  assign reserved_o = (kind_o == PCD_K_RESERVED);
  assign is_read_o = (kind_o == PCD_K_IO_RD) || (kind_o == PCD_K_MEM_RD) || (kind_o == PCD_K_CFG_RD)
                     || (kind_o == PCD_K_MEM_RD_MULT) || (kind_o == PCD_K_MEM_RD_LINE);
  assign is_mem_o = (kind_o == PCD_K_MEM_RD) || (kind_o == PCD_K_MEM_WR) || (kind_o == PCD_K_MEM_RD_MULT)
                    || (kind_o == PCD_K_MEM_RD_LINE) || (kind_o == PCD_K_MEM_WR_INV);
  assign is_io_o = (kind_o == PCD_K_IO_RD) || (kind_o == PCD_K_IO_WR);
  assign is_cfg_o = (kind_o == PCD_K_CFG_RD) || (kind_o == PCD_K_CFG_WR);
endmodule

// File: pcd_phase_decode_notes_unused.sv
`timescale 1ns/1ps

// File: pcd_props.sv
/* pcd_props: port-level timing checks for pcd_phase_decode.
   assumes bus inputs are the resolved wire levels. */
`timescale 1ns/1ps
module pcd_props
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // bus wire levels
  input wire logic [31:0] AD_I,
  input wire logic [3:0] CBE_N_I,
  input wire logic FRAME_N_I,
  input wire logic IRDY_N_I,
  input wire logic TRDY_N_I,
  input wire logic ATTN_REQ_I,
  // design outputs
  input wire logic AD_OE_O,
  input wire logic DEVSEL_N_O,
  input wire logic DEVSEL_OE_O,
  input wire logic TRDY_N_O,
  input wire logic TRDY_OE_O,
  input wire logic ATTN_N_O,
  input wire logic ATTN_OE_O,
  input wire logic ADDR_PHASE_O,
  input wire logic [31:0] ADDR_O,
  input wire logic [3:0] CMD_CODE_O,
  input wire logic CMD_RESERVED_O,
  input wire logic CLAIMED_O,
  input wire logic XFER_O,
  input wire logic [3:0] XFER_BE_O,
  input wire logic BUS_XFER_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // idle bus, then frame asserted
  sequence s_idle_frame;
    FRAME_N_I && IRDY_N_I ##1 !FRAME_N_I;
  endsequence
  // no claim, and no select drive after
  sequence s_no_claim;
    !CLAIMED_O ##1 !DEVSEL_OE_O [*2];
  endsequence
  a_addr_phase_seen: assert property (s_idle_frame |=> ADDR_PHASE_O)
    else $error("address phase missed");
  a_addr_capture: assert property (ADDR_PHASE_O |-> ADDR_O == $past(AD_I) && CMD_CODE_O == $past(CBE_N_I))
    else $error("address or command not captured");
  a_turn_around: assert property (ADDR_PHASE_O |-> TRDY_N_O && !AD_OE_O)
    else $error("drive before turnaround");
  a_devsel_park: assert property ($fell(DEVSEL_OE_O) |-> $past(DEVSEL_N_O))
    else $error("select released while low");
  a_trdy_park: assert property ($fell(TRDY_OE_O) |-> $past(TRDY_N_O))
    else $error("ready released while low");
  a_both_ready: assert property (BUS_XFER_O == $past(!IRDY_N_I && !TRDY_N_I))
    else $error("transfer flag wrong");
  a_be_lanes: assert property (XFER_O |-> XFER_BE_O == ~$past(CBE_N_I))
    else $error("lane enables wrong");
  a_rsvd_unclaimed: assert property (ADDR_PHASE_O && CMD_RESERVED_O |-> s_no_claim)
    else $error("reserved code claimed");
  a_attn_pull_low: assert property (ATTN_N_O == 1'b0 && ATTN_OE_O == $past(ATTN_REQ_I))
    else $error("open-drain line wrong");
endmodule

bind pcd_phase_decode pcd_props u_pcd_props (.*);

// File: pcd_initiator.sv
/* pcd_initiator: bus initiator model, one transaction per call.
   assumes the ready input is the resolved wire with pull-up. */
`timescale 1ns/1ps
module pcd_initiator
(
  // clock and resolved lines
  input wire logic clk_i,
  input wire logic [31:0] ad_i,
  input wire logic trdy_n_i,
  // initiator drive
  output logic [31:0] ad_o = 32'h0,
  output logic [3:0] cbe_n_o = 4'hf,
  output logic frame_n_o = 1'b1,
  output logic irdy_n_o = 1'b1
);
  logic [31:0] rdat = 32'h0;
  task automatic run(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] ben,
    input logic rd, input int n, input logic [31:0] wd, output int got);
    int w;
    got = 0;
    w = 0;
    #1 frame_n_o = 1'b0;
    ad_o = addr;
    cbe_n_o = cmd;
    @(posedge clk_i);
    #1 irdy_n_o = 1'b0;
    frame_n_o = (n == 1);
    cbe_n_o = ben;
    ad_o = rd ? ~addr : wd;
    while (got < n && w < 12)
    begin
      @(posedge clk_i);
      if (!trdy_n_i)
      begin
        if (rd)
          rdat = ad_i;
        got++;
        #1 frame_n_o = (got >= n - 1);
        irdy_n_o = (got == n);
        ad_o = rd ? ~ad_o : wd + got;
      end
      else
      begin
        w++;
        #1 ad_o = rd ? ~ad_o : ad_o;
      end
    end
    // no claim: frame first, ready one clock later
    if (got < n)
    begin
      #1 frame_n_o = 1'b1;
      @(posedge clk_i);
      #1 irdy_n_o = 1'b1;
    end
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// File: pci_phase_and_command_decode_bench.sv
/* bench for pcd_phase_decode with the initiator model.
   assumes the checker binds itself to the design. */
`timescale 1ns/1ps
module pci_phase_and_command_decode_bench;
  import pcd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic idsel = 1'b0;
  logic attn_req = 1'b0;
  logic tgt_rdy = 1'b1;
  logic [31:0] rd_data = 32'hc0de_5a01;
  wire [31:0] ini_ad, ad_o, addr_o, xdat;
  wire [3:0] cbe_n, xbe;
  wire frame_n, irdy_n, ad_oe, trdy_o, trdy_oe, attn_n, attn_oe;
  wire ap, rsv, rdc, cl, xf, act, xlast;
  pcd_kind_t kind, k_s;
  logic [2:0] r_s;
  logic [31:0] xd;
  logic [3:0] xb;
  int nx = 0;
  int nl = 0;
  int n_mismatch = 0;
  int checks_done = 0;
  // sustained line has a pull-up when undriven
  wire trdy_w = trdy_oe ? trdy_o : 1'b1;
  wire [31:0] ad_w = ad_oe ? ad_o : ini_ad;
  always #10 clk = ~clk;
  pcd_initiator u_pcd_initiator (.clk_i(clk), .ad_i(ad_w), .trdy_n_i(trdy_w), .ad_o(ini_ad),
    .cbe_n_o(cbe_n), .frame_n_o(frame_n), .irdy_n_o(irdy_n));
  pcd_phase_decode u_pcd_phase_decode (.CLOCK_I(clk), .RST_I(rst), .AD_I(ad_w), .CBE_N_I(cbe_n),
    .FRAME_N_I(frame_n), .IRDY_N_I(irdy_n), .TRDY_N_I(trdy_w), .IDSEL_I(idsel), .AD_O(ad_o),
    .AD_OE_O(ad_oe), .DEVSEL_N_O(), .DEVSEL_OE_O(), .TRDY_N_O(trdy_o), .TRDY_OE_O(trdy_oe),
    .ATTN_N_O(attn_n), .ATTN_OE_O(attn_oe), .ATTN_REQ_I(attn_req), .TARGET_READY_I(tgt_rdy),
    .RD_DATA_I(rd_data), .ADDR_PHASE_O(ap), .ADDR_O(addr_o), .CMD_CODE_O(), .CMD_KIND_O(kind),
    .CMD_RESERVED_O(rsv), .CMD_READ_O(rdc), .CLAIMED_O(cl), .ACTIVE_O(act), .XFER_O(xf),
    .XFER_DATA_O(xdat), .XFER_BE_O(xbe), .XFER_LAST_O(xlast), .BUS_XFER_O());
  always @(posedge clk)
  begin
    if (ap)
    begin
      k_s = kind;
      r_s = {rsv, rdc, cl};
    end
    if (xlast)
      nl++;
    if (xf)
    begin
      nx++;
      xd = xdat;
      xb = xbe;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // every code once; read and claim masks by code
  task automatic t_cmds;
    pcd_kind_t ek[16] = '{PCD_K_INT_ACK, PCD_K_SPECIAL, PCD_K_IO_RD, PCD_K_IO_WR, PCD_K_RESERVED,
      PCD_K_RESERVED, PCD_K_MEM_RD, PCD_K_MEM_WR, PCD_K_RESERVED, PCD_K_RESERVED, PCD_K_CFG_RD,
      PCD_K_CFG_WR, PCD_K_MEM_RD_MULT, PCD_K_DUAL_ADDR, PCD_K_MEM_RD_LINE, PCD_K_MEM_WR_INV};
    logic [15:0] rdm = 16'h5444;
    logic [15:0] clm = 16'hdccc;
    logic [31:0] a;
    int got;
    for (int c = 0; c < 16; c++)
    begin
      a = (c == 2 || c == 3) ? 32'h0000_1004 : (c == 10 || c == 11) ? 32'h0000_0010 : 32'h1000_0100;
      #1 idsel = (c == 10 || c == 11);
      u_pcd_initiator.run(4'(c), a, 4'h0, rdm[c], 1, 32'h0, got);
      check(32'(k_s), 32'(ek[c]));
      check(r_s, {ek[c] == PCD_K_RESERVED, rdm[c], clm[c]});
      check(got, clm[c]);
    end
    $display("test cmds done");
  endtask
  task automatic t_burst;
    int got, n0, l0;
    n0 = nx;
    l0 = nl;
    u_pcd_initiator.run(CMD_MEM_WR, 32'h1000_0200, 4'h6, 1'b0, 3, 32'h1234_0000, got);
    check(nx - n0, 3);
    check(nl - l0, 1);
    check(xd, 32'h1234_0002);
    check(xb, 4'h9);
    check(addr_o, 32'h1000_020c);
    $display("test burst done");
  endtask
  task automatic t_wait_read;
    int got, n0, l0;
    #1 tgt_rdy = 1'b0;
    n0 = nx;
    l0 = nl;
    fork
      u_pcd_initiator.run(CMD_MEM_RD_LINE, 32'h1000_0300, 4'h0, 1'b1, 1, 32'h0, got);
      begin
        repeat (5) @(posedge clk);
        check(nx - n0, 0);
        #1 tgt_rdy = 1'b1;
        check(act, 1'b1);
      end
    join
    check(act, 1'b0);
    check(nl - l0, 1);
    check(u_pcd_initiator.rdat, rd_data);
    check(xd, rd_data);
    check(xb, 4'hf);
    $display("test wait read done");
  endtask
  task automatic t_attn;
    #1 attn_req = 1'b1;
    repeat (2) @(posedge clk);
    check({attn_oe, attn_n}, 2'b10);
    #1 attn_req = 1'b0;
    repeat (2) @(posedge clk);
    check({attn_oe, attn_n}, 2'b00);
    $display("test attn done");
  endtask
  initial
  begin
    #500000;
    n_mismatch++;
    summarize;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    t_cmds;
    t_burst;
    t_wait_read;
    t_attn;
    summarize;
  end
endmodule
